// File: logic/deint_ctrl_pkg.sv
// constants, field layouts and carriers for the deinterlacer run-time
// control bank; assumes one 40 MHz processing clock and a 2-bit
// word address on the control slave port.
//
// Operation
// - one register set per build, never both
// - motion mode: sample controls before each output frame
// - motion mode: run clear halts before next frame
// - motion halt with triple buffering: drop input
// - status at bit 0 of word 1
// - word 2 bit 0 forces blend coefficient
// - word 3: 16-bit blend, 0 weave, max bob
// - rate mode: sample controls at frame header
// - rate mode: run clear halts before next input
// - rate halt with triple buffering: repeat frame
// - rate mode: word 2 holds input rate
// - rate mode: word 3 holds output rate
package deint_ctrl_pkg;

    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 16;

    // word offsets on the control port
    localparam logic [1:0] OFS_RUN_CTRL = 2'h0;
    localparam logic [1:0] OFS_RUN_STATE = 2'h1;
    localparam logic [1:0] OFS_WORD2 = 2'h2;
    localparam logic [1:0] OFS_WORD3 = 2'h3;

    // field positions
    localparam int unsigned RUN_BIT = 0;
    localparam int unsigned STATE_BIT = 0;
    localparam int unsigned OVERRIDE_BIT = 0;
    localparam int unsigned RATE_LSB = 0;
    localparam int unsigned RATE_W = 8;
    localparam int unsigned BLEND_W = 16;

    // values after reset, plus the weave and bob blend values
    localparam logic RUN_RST = 1'b0;
    localparam logic OVERRIDE_RST = 1'b0;
    localparam logic [15:0] BLEND_RST = 16'h0000;
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [15:0] RDATA_ZERO = 16'h0000;
    localparam logic [15:0] BLEND_WEAVE = 16'h0000;
    localparam logic [15:0] BLEND_BOB = 16'hffff;

    typedef enum logic [1:0] {
        ST_HALTED = 2'b01,
        ST_RUNNING = 2'b10
    } run_state_e;

    // control values handed to the datapath once per frame
    typedef struct packed {
        logic override_en;
        logic [BLEND_W-1:0] blend;
        logic [RATE_W-1:0] in_rate;
        logic [RATE_W-1:0] out_rate;
    } frame_ctrl_s;

    // one host access on the control port
    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_req_s;

endpackage

// File: logic/deint_runtime_ctrl.sv
// run-time control bank of the deinterlacer: host registers, frame
// boundary sampling, halt/resume and a two-entry hand-off buffer.
// assumes the datapath raises frame_req at each frame boundary and
// holds it until taken; all inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module deint_runtime_ctrl
    import deint_ctrl_pkg::*;
#(
    parameter bit RATE_MODE = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host control port, read data one cycle after the read
    input wire host_req_s host_req,
    output logic [DATA_W-1:0] host_rdata,
    // datapath configuration
    input wire logic triple_buf_en,
    // frame boundary request from the datapath
    input wire logic frame_req,
    output logic frame_req_ready,
    // sampled control values towards the datapath
    output frame_ctrl_s frame_ctrl,
    output logic frame_ctrl_valid,
    input wire logic frame_ctrl_ready,
    // halt behaviour towards the datapath
    output logic drop_input,
    output logic repeat_frame
);

    ////////////////////////////////////////////////////////////////////
    // host registers

    logic run_r;
    logic run_nxt;
    logic override_r;
    logic [BLEND_W-1:0] blend_r;
    logic [RATE_W-1:0] in_rate_r;
    logic [RATE_W-1:0] out_rate_r;
    logic wr_run;
    logic wr_w2;
    logic wr_w3;

    assign wr_run = host_req.write && host_req.addr == OFS_RUN_CTRL;
    assign wr_w2 = host_req.write && host_req.addr == OFS_WORD2;
    assign wr_w3 = host_req.write && host_req.addr == OFS_WORD3;
    assign run_nxt = wr_run ? host_req.wdata[RUN_BIT] : run_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r <= RUN_RST;
        end else begin
            run_r <= run_nxt;
        end
    end

    // only the set chosen at build time exists
    generate
        if (RATE_MODE) begin : g_rate
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    in_rate_r <= RATE_RST;
                    out_rate_r <= RATE_RST;
                end else begin
                    if (wr_w2) begin
                        in_rate_r <= host_req.wdata[RATE_LSB +: RATE_W];
                    end
                    if (wr_w3) begin
                        out_rate_r <= host_req.wdata[RATE_LSB +: RATE_W];
                    end
                end
            end
            assign override_r = OVERRIDE_RST;
            assign blend_r = BLEND_RST;
        end else begin : g_motion
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    override_r <= OVERRIDE_RST;
                    blend_r <= BLEND_RST;
                end else begin
                    if (wr_w2) begin
                        override_r <= host_req.wdata[OVERRIDE_BIT];
                    end
                    if (wr_w3) begin
                        blend_r <= host_req.wdata;
                    end
                end
            end
            assign in_rate_r = RATE_RST;
            assign out_rate_r = RATE_RST;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // run state: halts only at a frame boundary

    run_state_e state_r;
    run_state_e state_nxt;
    logic take;

    // ready already implies run was set when it was raised
    assign take = frame_req && frame_req_ready;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUNNING: begin
                if (frame_req && !run_r) begin
                    state_nxt = ST_HALTED;
                end
            end
            ST_HALTED: begin
                if (run_r) begin
                    state_nxt = ST_RUNNING;
                end
            end
            default: state_nxt = ST_HALTED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_HALTED;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two-entry hand-off buffer; a stalled datapath loses no sample

    frame_ctrl_s sample;
    frame_ctrl_s skid_r;
    logic skid_valid_r;
    logic skid_valid_nxt;
    logic out_free;

    always_comb begin
        sample.override_en = override_r;
        sample.blend = blend_r;
        sample.in_rate = in_rate_r;
        sample.out_rate = out_rate_r;
    end

    assign out_free = !frame_ctrl_valid || frame_ctrl_ready;

    always_comb begin
        skid_valid_nxt = skid_valid_r;
        if (out_free) begin
            skid_valid_nxt = 1'b0;
        end else if (take) begin
            skid_valid_nxt = 1'b1;
        end
    end

    // the whole set is latched in one edge at the boundary
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_ctrl <= '0;
            frame_ctrl_valid <= 1'b0;
            skid_r <= '0;
            skid_valid_r <= 1'b0;
        end else begin
            skid_valid_r <= skid_valid_nxt;
            if (out_free) begin
                if (skid_valid_r) begin
                    frame_ctrl <= skid_r;
                    frame_ctrl_valid <= 1'b1;
                end else begin
                    frame_ctrl <= sample;
                    frame_ctrl_valid <= take;
                end
            end
            if (take && !out_free) begin
                skid_r <= sample;
            end
        end
    end

    // registered so that ready never outlives a cleared run bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_req_ready <= 1'b0;
        end else begin
            frame_req_ready <= state_nxt == ST_RUNNING && run_nxt &&
                               !skid_valid_nxt && !wr_w2 && !wr_w3;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt behaviour flags

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drop_input <= 1'b0;
            repeat_frame <= 1'b0;
        end else begin
            drop_input <= !RATE_MODE && triple_buf_en &&
                          state_nxt == ST_HALTED;
            repeat_frame <= RATE_MODE && triple_buf_en &&
                            state_nxt == ST_HALTED;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // host read path; reads change nothing but host_rdata

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            host_rdata <= RDATA_ZERO;
        end else begin
            host_rdata <= RDATA_ZERO;
            if (host_req.read) begin
                case (host_req.addr)
                    OFS_RUN_CTRL: host_rdata[RUN_BIT] <= run_r;
                    OFS_RUN_STATE: begin
                        host_rdata[STATE_BIT] <= state_r == ST_RUNNING;
                    end
                    default: host_rdata <= RDATA_ZERO;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_boundary_idle;
        frame_req && !run_r && state_r == ST_RUNNING;
    endsequence

    sequence s_halted_hold;
        state_r == ST_HALTED && !frame_req_ready;
    endsequence

    a_halt_no_take: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_boundary_idle |-> !take ##1 s_halted_hold
    ) else $error("boundary with run clear was not halted");

    a_sample_latch: assert property (
        @(posedge clk) disable iff (!rst_b)
        take && out_free && !skid_valid_r |=>
            frame_ctrl_valid && frame_ctrl == $past(sample)
    ) else $error("sampled controls do not match registers");

    a_skid_keep: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_ctrl_valid && !frame_ctrl_ready |=>
            frame_ctrl_valid && $stable(frame_ctrl)
    ) else $error("stalled sample changed");

    a_status_read: assert property (
        @(posedge clk) disable iff (!rst_b)
        host_req.read && host_req.addr == OFS_RUN_STATE |=>
            host_rdata == {15'h0, ($past(state_r) == ST_RUNNING)}
    ) else $error("status read wrong");

    a_wo_read_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        host_req.read && host_req.addr[1] |=>
            host_rdata == RDATA_ZERO && $stable(run_r)
    ) else $error("write-only word read back nonzero");

    a_word2_write: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_w2 |=> (RATE_MODE ? in_rate_r == $past(host_req.wdata[7:0])
                  : override_r == $past(host_req.wdata[0]))
    ) else $error("word 2 write not stored");

    a_word3_write: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_w3 |=> (RATE_MODE ? out_rate_r == $past(host_req.wdata[7:0])
                  : blend_r == $past(host_req.wdata))
    ) else $error("word 3 write not stored");

    a_one_set: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_ctrl_valid |->
            (RATE_MODE ? (!frame_ctrl.override_en
                          && frame_ctrl.blend == BLEND_WEAVE)
             : (frame_ctrl.in_rate == RATE_RST
                && frame_ctrl.out_rate == RATE_RST))
    ) else $error("both register sets active");

    a_halt_flags: assert property (
        @(posedge clk) disable iff (!rst_b)
        ##1 (drop_input || repeat_frame) |->
            state_r == ST_HALTED && $past(triple_buf_en)
            && !(drop_input && repeat_frame)
    ) else $error("halt flag without halt");

    sequence s_w23_write;
        wr_w2 || wr_w3;
    endsequence

    sequence s_halt_wait;
        state_r == ST_HALTED && !run_r && triple_buf_en;
    endsequence

    // ready falls in the same edge as run, so a clear bit never lets one through
    a_ready_run_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        !run_r |-> !frame_req_ready
    ) else $error("ready high with run clear");

    a_halt_resume: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_HALTED && run_r |=> state_r == ST_RUNNING
    ) else $error("halted block did not resume");

    a_write_gap: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_w23_write |=> !frame_req_ready
    ) else $error("ready not withheld after a value write");

    a_skid_full: assert property (
        @(posedge clk) disable iff (!rst_b)
        skid_valid_r |-> !frame_req_ready
    ) else $error("ready high with skid entry full");

    a_halt_drop: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_halt_wait |=> drop_input == !RATE_MODE
            && repeat_frame == RATE_MODE
    ) else $error("halt flag missing while halted");

    a_run_flags_low: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_RUNNING && !frame_req |=>
            !drop_input && !repeat_frame
    ) else $error("halt flag while running");

    a_run_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        host_req.read && host_req.addr == OFS_RUN_CTRL |=>
            host_rdata == {15'h0, $past(run_r)}
    ) else $error("run bit read wrong");

    a_idle_rdata: assert property (
        @(posedge clk) disable iff (!rst_b)
        !host_req.read |=> host_rdata == RDATA_ZERO
    ) else $error("read data without a read");

endmodule

`default_nettype wire

// File: tb/host_model.sv
// host processor model on the control port of both bank builds
// assumes the bench calls wr and rd; requests change 2 ns after clk rises
`timescale 1ns/1ps
`default_nettype none

module host_model
    import deint_ctrl_pkg::*;
(
    // clock
    input wire logic clk,
    // control port, shared by both builds
    output var host_req_s req,
    input wire logic [DATA_W-1:0] rd_m,
    input wire logic [DATA_W-1:0] rd_r
);
    initial req = '0;

    ////////////////////////////////////////////////////////////////////////
    // one access per task, idle cycle after it so requests never merge
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        #2 req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #2 req = '0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [15:0] m,
                      output logic [15:0] r);
        @(posedge clk);
        #2 req = '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        #1 m = rd_m;
        r = rd_r;
        #1 req = '0;
    endtask
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// bench for both register-set builds of the run-time control bank
// assumes the host model above; frame side is driven here
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import deint_ctrl_pkg::*;
;
    logic clk, rst_b, tbe, freq, fcr;
    logic rdy_m, rdy_r, v_m, v_r, drop_m, drop_r, rep_m, rep_r;
    logic [15:0] rd_m, rd_r, m, r, lf, w2, w3;
    host_req_s req;
    frame_ctrl_s fc_m, fc_r;
    frame_ctrl_s q_m[$];
    frame_ctrl_s q_r[$];
    int err_total, n_compared;
    int cyc = 0;

    host_model u_host (.clk(clk), .req(req), .rd_m(rd_m), .rd_r(rd_r));
    deint_runtime_ctrl #(.RATE_MODE(1'b0)) u_dut (
        .clk(clk), .rst_b(rst_b), .host_req(req), .host_rdata(rd_m),
        .triple_buf_en(tbe), .frame_req(freq), .frame_req_ready(rdy_m),
        .frame_ctrl(fc_m), .frame_ctrl_valid(v_m), .frame_ctrl_ready(fcr),
        .drop_input(drop_m), .repeat_frame(rep_m));
    deint_runtime_ctrl #(.RATE_MODE(1'b1)) u_dut_rate (
        .clk(clk), .rst_b(rst_b), .host_req(req), .host_rdata(rd_r),
        .triple_buf_en(tbe), .frame_req(freq), .frame_req_ready(rdy_r),
        .frame_ctrl(fc_r), .frame_ctrl_valid(v_r), .frame_ctrl_ready(fcr),
        .drop_input(drop_r), .repeat_frame(rep_r));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ceiling far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // request held until both builds take it at the same edge
    task automatic take();
        int n;
        @(posedge clk);
        #2 freq = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(rdy_m && rdy_r) && n < 50);
        chk(n < 50, 1'b1);
        q_m.push_back('{w2[0], w3, 8'h00, 8'h00});
        q_r.push_back('{1'b0, 16'h0000, w2[7:0], w3[7:0]});
        @(posedge clk);
        #2 freq = 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (!(v_m && v_r) && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(n < 50, 1'b1);
        chk(fc_m, q_m.pop_front());
        chk(fc_r, q_r.pop_front());
        @(posedge clk);
        #2 fcr = 1'b1;
        @(posedge clk);
        #2 fcr = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        tbe = 1'b0;
        freq = 1'b0;
        fcr = 1'b0;
        err_total = 0;
        n_compared = 0;
        lf = 16'h0013;
        w2 = 16'h0000;
        w3 = 16'h0000;
        repeat (4) @(posedge clk);
        #2 rst_b = 1'b1;
        u_host.rd(OFS_RUN_STATE, m, r);
        chk({m, r}, 32'h0000_0000);
        u_host.wr(OFS_RUN_CTRL, 16'hffff);
        u_host.rd(OFS_RUN_CTRL, m, r);
        chk({m, r}, 32'h0001_0001);
        u_host.rd(OFS_RUN_STATE, m, r);
        chk({m, r}, 32'h0001_0001);
        for (int i = 0; i < 12; i++) begin
            lf = lfsr(lf);
            w2 = lf;
            lf = lfsr(lf);
            w3 = (i == 0) ? BLEND_WEAVE : (i == 1) ? BLEND_BOB : lf;
            u_host.wr(OFS_WORD2, w2);
            u_host.wr(OFS_WORD3, w3);
            u_host.rd(i[0] ? OFS_WORD3 : OFS_WORD2, m, r);
            chk({m, r}, 32'h0000_0000);
            take();
            // second frame waits in the skid; a third must be refused
            if (i[0]) begin
                @(posedge clk);
                #2 freq = 1'b1;
                repeat (4) @(posedge clk);
                #2 chk({rdy_m, rdy_r}, 2'b00);
                freq = 1'b0;
                drain();
                drain();
            end
        end
        // halt with triple buffering, then resume
        tbe = 1'b1;
        u_host.wr(OFS_RUN_CTRL, 16'h0000);
        @(posedge clk);
        #2 freq = 1'b1;
        repeat (6) @(posedge clk);
        #2 chk({rdy_m, rdy_r}, 2'b00);
        chk({drop_m, rep_m, drop_r, rep_r}, 4'b1001);
        u_host.rd(OFS_RUN_STATE, m, r);
        chk({m, r}, 32'h0000_0000);
        u_host.wr(OFS_RUN_CTRL, 16'h0001);
        take();
        chk({drop_m, rep_m, drop_r, rep_r}, 4'b0000);
        drain();
        complete_run();
    end
endmodule

`default_nettype wire
